// [design/pdc_pkg.sv]
// Package for the two-port direction and data block
// Assumes a classic Wishbone slave with 32-bit data, byte addresses
package pdc_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned PORT_W          = 8;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_A_DATA  = 8'h00;
  localparam logic [7:0] OFS_PORT_D_DATA  = 8'h04;
  localparam logic [7:0] OFS_PORT_A_DIR   = 8'h08;
  localparam logic [7:0] OFS_PORT_D_DIR   = 8'h0c;
  localparam logic [7:0] OFS_ANALOG_SEL   = 8'h10;
  localparam logic [7:0] OFS_KEY_WAKE     = 8'h14;
  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DIR          = 8'h00;
  localparam logic [7:0] RST_DATA         = 8'h00;
  localparam logic [4:0] RST_ANALOG_SEL   = 5'h1f;
  localparam logic [3:0] RST_KEY_WAKE     = 4'h0;
  localparam int unsigned ANALOG_SEL_W    = 5;
  localparam int unsigned KEY_WAKE_LSB    = 4;
  localparam int unsigned KEY_WAKE_W      = 4;
  // Port A pins 4..7 carry analog channels 0..3
  localparam int unsigned ANALOG_PIN_LSB  = 4;
  localparam int unsigned ANALOG_CH_CNT   = 4;
endpackage

// [design/pdc_port_direction_control.sv]
// Two 8-bit ports with direction, data, analog and key-wake overrides
// Assumes a classic Wishbone master on SYS_CLK; pins resolved by the bench
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
// Behaviour
// - Port A direction one enables pin driver
// - Reset clears all port A direction bits
// - Port D direction one enables pin driver
// - Reset clears all port D direction bits
// - Direction registers read back last written value
// - Selected analog channel overrides port A pin
// - Unselected shared pins stay normal port pins
// - Key wake enable overrides port control
module pdc_port_direction_control
  import pdc_pkg::*;
(
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [pdc_pkg::ADDR_W-1:0]    WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [31:0]                   WB_DAT_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  input  wire logic [pdc_pkg::PORT_W-1:0]    PORT_A_IN,
  output logic      [pdc_pkg::PORT_W-1:0]    PORT_A_OUT,
  output logic      [pdc_pkg::PORT_W-1:0]    PORT_A_OE,
  input  wire logic [pdc_pkg::PORT_W-1:0]    PORT_D_PINS_IN,
  output logic      [pdc_pkg::PORT_W-1:0]    PORT_D_PINS_OUT,
  output logic      [pdc_pkg::PORT_W-1:0]    PORT_D_PINS_OE,
  output logic      [pdc_pkg::PORT_W-1:0]    ANALOG_PIN_SEL,
  output logic      [pdc_pkg::PORT_W-1:0]    KEY_WAKE_INPUTS
);
  import pdc_pkg::*;

  // ------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------
  logic [PORT_W-1:0] a_meta_r,  a_sync_r,  d_meta_r,  d_sync_r;

  always_ff @(posedge SYS_CLK) begin
    a_meta_r <= PORT_A_IN;
    a_sync_r <= a_meta_r;
    d_meta_r <= PORT_D_PINS_IN;
    d_sync_r <= d_meta_r;
  end

  // ------------------------------------------------------------
  // Register file and bus slave
  // ------------------------------------------------------------
  logic [PORT_W-1:0]       port_a_direction_r, port_a_direction_nxt;
  logic [PORT_W-1:0]       port_d_direction_r, port_d_direction_nxt;
  logic [PORT_W-1:0]       port_a_data_r,      port_a_data_nxt;
  logic [PORT_W-1:0]       port_d_data_r,      port_d_data_nxt;
  logic [ANALOG_SEL_W-1:0] analog_channel_select_r, analog_channel_select_nxt;
  logic [KEY_WAKE_W-1:0]   key_wake_enable_r,  key_wake_enable_nxt;
  logic                    ack_r,              ack_nxt;
  logic [31:0]             rdata_r,            rdata_nxt;
  logic                    wr_hit;

  // Pin value seen by a read: output latch where the direction bit is one, else pin level
  function automatic logic [PORT_W-1:0] pin_view(input logic [PORT_W-1:0] dir,
                                                 input logic [PORT_W-1:0] dat,
                                                 input logic [PORT_W-1:0] pin);
    pin_view = (dir & dat) | (~dir & pin);
  endfunction

  // Shared port A pins taken over by a peripheral
  function automatic logic [PORT_W-1:0] analog_mask(input logic [ANALOG_SEL_W-1:0] sel);
    analog_mask = '0;
    if (sel < ANALOG_SEL_W'(ANALOG_CH_CNT)) begin
      analog_mask[ANALOG_PIN_LSB + 32'(sel)] = 1'b1;
    end
  endfunction

  always_comb begin
    port_a_direction_nxt      = port_a_direction_r;
    port_d_direction_nxt      = port_d_direction_r;
    port_a_data_nxt           = port_a_data_r;
    port_d_data_nxt           = port_d_data_r;
    analog_channel_select_nxt = analog_channel_select_r;
    key_wake_enable_nxt       = key_wake_enable_r;
    ack_nxt                   = 1'b0;
    rdata_nxt                 = rdata_r;
    wr_hit                    = WB_CYC_I && WB_STB_I && !ack_r && WB_WE_I && WB_SEL_I[0];
    if (WB_CYC_I && WB_STB_I && !ack_r) begin
      ack_nxt   = 1'b1;
      rdata_nxt = 32'h0000_0000;
      unique case (WB_ADR_I)
        OFS_PORT_A_DATA: rdata_nxt[7:0] = pin_view(port_a_direction_r, port_a_data_r,
                                                   a_sync_r);
        OFS_PORT_D_DATA: rdata_nxt[7:0] = pin_view(port_d_direction_r, port_d_data_r,
                                                   d_sync_r);
        OFS_PORT_A_DIR:  rdata_nxt[7:0] = port_a_direction_r;
        OFS_PORT_D_DIR:  rdata_nxt[7:0] = port_d_direction_r;
        OFS_ANALOG_SEL:  rdata_nxt[4:0] = analog_channel_select_r;
        OFS_KEY_WAKE:    rdata_nxt[7:4] = key_wake_enable_r;
        default:         rdata_nxt      = 32'h0000_0000;
      endcase
      if (wr_hit) begin
        unique case (WB_ADR_I)
          OFS_PORT_A_DATA: port_a_data_nxt           = WB_DAT_I[7:0];
          OFS_PORT_D_DATA: port_d_data_nxt           = WB_DAT_I[7:0];
          OFS_PORT_A_DIR:  port_a_direction_nxt      = WB_DAT_I[7:0];
          OFS_PORT_D_DIR:  port_d_direction_nxt      = WB_DAT_I[7:0];
          OFS_ANALOG_SEL:  analog_channel_select_nxt = WB_DAT_I[4:0];
          OFS_KEY_WAKE:    key_wake_enable_nxt       = WB_DAT_I[7:4];
          default:         port_a_data_nxt           = port_a_data_r;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      port_a_direction_r      <= RST_DIR;
      port_d_direction_r      <= RST_DIR;
      port_a_data_r           <= RST_DATA;
      port_d_data_r           <= RST_DATA;
      analog_channel_select_r <= RST_ANALOG_SEL;
      key_wake_enable_r       <= RST_KEY_WAKE;
      ack_r                   <= 1'b0;
      rdata_r                 <= 32'h0000_0000;
    end else begin
      port_a_direction_r      <= port_a_direction_nxt;
      port_d_direction_r      <= port_d_direction_nxt;
      port_a_data_r           <= port_a_data_nxt;
      port_d_data_r           <= port_d_data_nxt;
      analog_channel_select_r <= analog_channel_select_nxt;
      key_wake_enable_r       <= key_wake_enable_nxt;
      ack_r                   <= ack_nxt;
      rdata_r                 <= rdata_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;

  // ------------------------------------------------------------
  // Pin drivers with peripheral overrides
  // ------------------------------------------------------------
  logic [PORT_W-1:0] a_oe_r, a_oe_nxt, a_out_r, a_out_nxt;
  logic [PORT_W-1:0] d_oe_r, d_oe_nxt, d_out_r, d_out_nxt;
  logic [PORT_W-1:0] an_sel_r, an_sel_nxt, kw_r, kw_nxt;

  always_comb begin
    an_sel_nxt = analog_mask(analog_channel_select_nxt);
    // Key wake pins are port D pins 7..4
    kw_nxt     = {key_wake_enable_nxt, {KEY_WAKE_LSB{1'b0}}};
    a_oe_nxt   = port_a_direction_nxt & ~an_sel_nxt;
    a_out_nxt  = port_a_data_nxt & a_oe_nxt;
    d_oe_nxt   = port_d_direction_nxt & ~kw_nxt;
    d_out_nxt  = port_d_data_nxt & d_oe_nxt;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      a_oe_r   <= RST_DIR;
      a_out_r  <= RST_DATA;
      d_oe_r   <= RST_DIR;
      d_out_r  <= RST_DATA;
      an_sel_r <= 8'h00;
      kw_r     <= 8'h00;
    end else begin
      a_oe_r   <= a_oe_nxt;
      a_out_r  <= a_out_nxt;
      d_oe_r   <= d_oe_nxt;
      d_out_r  <= d_out_nxt;
      an_sel_r <= an_sel_nxt;
      kw_r     <= kw_nxt;
    end
  end

  assign PORT_A_OE       = a_oe_r;
  assign PORT_A_OUT      = a_out_r;
  assign PORT_D_PINS_OE  = d_oe_r;
  assign PORT_D_PINS_OUT = d_out_r;
  assign ANALOG_PIN_SEL  = an_sel_r;
  assign KEY_WAKE_INPUTS = kw_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_dir_a_write;
    WB_CYC_I && WB_STB_I && !ack_r && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == OFS_PORT_A_DIR;
  endsequence

  property p_a_oe_follows;
    @(posedge SYS_CLK) disable iff (RST)
      s_dir_a_write ##1 (analog_channel_select_r >= 5'h04)
      |-> PORT_A_OE == $past(WB_DAT_I[7:0]);
  endproperty
  a_a_oe_follows: assert property (p_a_oe_follows) else $error("port A enable wrong");

  property p_a_reset;
    @(posedge SYS_CLK) $past(RST) |-> PORT_A_OE == 8'h00 && port_a_direction_r == 8'h00;
  endproperty
  a_a_reset: assert property (p_a_reset) else $error("port A not input after reset");

  property p_d_oe;
    @(posedge SYS_CLK) disable iff (RST)
      (key_wake_enable_r == 4'h0) |-> PORT_D_PINS_OE == port_d_direction_r;
  endproperty
  a_d_oe: assert property (p_d_oe) else $error("port D enable wrong");

  property p_d_reset;
    @(posedge SYS_CLK) $past(RST) |-> PORT_D_PINS_OE == 8'h00;
  endproperty
  a_d_reset: assert property (p_d_reset) else $error("port D not input after reset");

  property p_readback;
    @(posedge SYS_CLK) disable iff (RST)
      (WB_CYC_I && WB_STB_I && !ack_r && !WB_WE_I && WB_ADR_I == OFS_PORT_D_DIR)
      |=> WB_ACK_O && WB_DAT_O == {24'h000000, port_d_direction_r};
  endproperty
  a_readback: assert property (p_readback) else $error("direction readback wrong");

  property p_analog;
    @(posedge SYS_CLK) disable iff (RST)
      (analog_channel_select_r == 5'h01) |-> !PORT_A_OE[5] && ANALOG_PIN_SEL[5];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin not taken");

  property p_unselected;
    @(posedge SYS_CLK) disable iff (RST)
      (analog_channel_select_r == 5'h1f)
      |-> PORT_A_OE == port_a_direction_r;
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected pin overridden");

  property p_key;
    @(posedge SYS_CLK) disable iff (RST)
      (key_wake_enable_r != 4'h0)
      |-> (PORT_D_PINS_OE[7:4] & key_wake_enable_r) == 4'h0
          && KEY_WAKE_INPUTS[7:4] == key_wake_enable_r;
  endproperty
  a_key: assert property (p_key) else $error("key wake pin driven");

  property p_drive;
    @(posedge SYS_CLK) disable iff (RST)
      (PORT_D_PINS_OUT & ~port_d_data_r) == 8'h00 && (PORT_D_PINS_OUT & ~PORT_D_PINS_OE) == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("pin data wrong");
endmodule

// [test/pdc_pin_model.sv]
// Package pin model: resolves port A and port D pins
// Assumes the block drives OUT/OE and outside circuits drive undriven pins
`timescale 1ns/10ps
module pdc_pin_model (
  input  wire logic [7:0] out_a,
  input  wire logic [7:0] oe_a,
  input  wire logic [7:0] out_d,
  input  wire logic [7:0] oe_d,
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_d,
  output logic      [7:0] in_a,
  output logic      [7:0] in_d
);
  // ----------------------------------------
  // Driven bits follow the block, others follow the outside source
  // ----------------------------------------
  assign in_a = (oe_a & out_a) | (~oe_a & ext_a);
  assign in_d = (oe_d & out_d) | (~oe_d & ext_d);
endmodule

// [test/tb_port_direction_control.sv]
// Self-checking bench for the two-port direction block
// Assumes pdc_pkg offsets; bench acts as classic Wishbone master
`timescale 1ns/10ps
module tb_port_direction_control;
  import pdc_pkg::*;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0]  adr = 0, ext_a = 8'h3c, ext_d = 8'hc3;
  logic [3:0]  sel = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [7:0]  ain, aout, aoe, din, dout, doe, asel, kw;
  int          errors = 0, num_checks = 0;

  pdc_port_direction_control dut (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PORT_A_IN(ain), .PORT_A_OUT(aout), .PORT_A_OE(aoe),
    .PORT_D_PINS_IN(din), .PORT_D_PINS_OUT(dout), .PORT_D_PINS_OE(doe),
    .ANALOG_PIN_SEL(asel), .KEY_WAKE_INPUTS(kw));
  pdc_pin_model pins (.out_a(aout), .oe_a(aoe), .out_d(dout), .oe_d(doe),
    .ext_a(ext_a), .ext_d(ext_d), .in_a(ain), .in_d(din));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // ----------------------------------------
  // Classic single cycle, held until ack
  // ----------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, 32'h0, 32'h1);
      give_verdict();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic t_reset();
    chk(aoe, 8'h00);
    chk(doe, 8'h00);
    rdc(OFS_PORT_A_DIR, 32'h0);
    rdc(OFS_PORT_D_DIR, 32'h0);
    rdc(8'h40, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_dir();
    wb(1'b1, OFS_PORT_A_DATA, 32'h5a);
    wb(1'b1, OFS_PORT_A_DIR, 32'h96);
    chk(aoe, 8'h96);
    chk(aout & aoe, 8'h12);
    rdc(OFS_PORT_A_DIR, 32'h96);
    wb(1'b1, OFS_PORT_D_DATA, 32'ha5);
    wb(1'b1, OFS_PORT_D_DIR, 32'h69);
    chk(doe, 8'h69);
    chk(dout & doe, 8'h21);
    rdc(OFS_PORT_D_DIR, 32'h69);
    repeat (3) @(posedge clk);
    rdc(OFS_PORT_A_DATA, 32'h3a);
    rdc(OFS_PORT_D_DATA, 32'ha3);
    $display("test direction done");
  endtask

  task automatic t_analog();
    logic [7:0] m;
    wb(1'b1, OFS_PORT_A_DIR, 32'hff);
    for (int ch = 0; ch < 5; ch++) begin
      m = (ch < 4) ? (8'h10 << ch) : 8'h00;
      wb(1'b1, OFS_ANALOG_SEL, 32'(ch));
      chk(asel, m);
      chk(aoe, 8'hff & ~m);
    end
    wb(1'b1, OFS_ANALOG_SEL, 32'h1f);
    chk(aoe, 8'hff);
    $display("test analog done");
  endtask

  task automatic t_key();
    wb(1'b1, OFS_KEY_WAKE, 32'ha0);
    chk(kw, 8'ha0);
    chk(doe, 8'h49);
    chk(aoe, 8'hff);
    rdc(OFS_PORT_A_DIR, 32'hff);
    rdc(OFS_PORT_D_DIR, 32'h69);
    rdc(OFS_KEY_WAKE, 32'ha0);
    wb(1'b1, OFS_KEY_WAKE, 32'h00);
    chk(doe, 8'h69);
    wb(1'b1, OFS_PORT_D_DIR, 32'hff);
    chk(doe, 8'hff);
    $display("test key wake done");
  endtask

  task automatic t_rerst();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(aoe, 8'h00);
    chk(doe, 8'h00);
    chk(kw, 8'h00);
    rdc(OFS_PORT_A_DIR, 32'h0);
    rdc(OFS_PORT_D_DIR, 32'h0);
    $display("test second reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_dir();
    t_analog();
    t_key();
    t_rerst();
    give_verdict();
  end
endmodule
